//--- jtap_pkg.sv
// constants and types for the jtag test access port
package jtap_pkg;
	localparam int JTAP_IR_WIDTH = 4;
	localparam logic [3:0] JTAP_IR_RESET = 4'h1;
	localparam logic [3:0] JTAP_IR_BYPASS = 4'hF;
	localparam logic [1:0] JTAP_IR_CAPTURE = 2'h1;
	localparam logic [3:0] JTAP_IR_USER = 4'h2;
	localparam int JTAP_DR_WIDTH = 16;
	localparam logic [15:0] JTAP_USER_RESET = 16'h0000;
	localparam logic [1:0] JTAP_SYNC_FILL = 2'h3;

	typedef enum logic [15:0] {
		JTAP_TLR  = 16'h0001,
		JTAP_RTI  = 16'h0002,
		JTAP_SDRS = 16'h0004,
		JTAP_CDR  = 16'h0008,
		JTAP_SDR  = 16'h0010,
		JTAP_E1DR = 16'h0020,
		JTAP_PDR  = 16'h0040,
		JTAP_E2DR = 16'h0080,
		JTAP_UDR  = 16'h0100,
		JTAP_SIRS = 16'h0200,
		JTAP_CIR  = 16'h0400,
		JTAP_SIR  = 16'h0800,
		JTAP_E1IR = 16'h1000,
		JTAP_PIR  = 16'h2000,
		JTAP_E2IR = 16'h4000,
		JTAP_UIR  = 16'h8000
	} jtap_state_t;
endpackage

//--- jtap_top.sv
// jtag test access port controller with user data register and clock-crossed readout
`timescale 1ns/1ps
module jtap_top
	import jtap_pkg::*;
#(
	parameter int IR_WIDTH = JTAP_IR_WIDTH,
	parameter int DR_WIDTH = JTAP_DR_WIDTH
)
(
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                tck,
	input  wire logic                tms,
	input  wire logic                tdi,
	input  wire logic                trst_n,
	output logic                     tdo,
	output logic                     tdo_oe,
	input  wire logic [DR_WIDTH-1:0] user_status,
	output logic [DR_WIDTH-1:0]      user_data,
	output logic                     user_update
);
	jtap_state_t                state;
	jtap_state_t                next_state;
	logic [IR_WIDTH-1:0]        ir_shift;
	logic [IR_WIDTH-1:0]        ir;
	logic [DR_WIDTH-1:0]        dr_shift;
	logic [DR_WIDTH-1:0]        dr_hold;
	logic                       bypass_bit;
	logic                       upd_toggle;
	logic [2:0]                 upd_sync;
	logic                       serial_out;
	logic                       user_sel;
	logic [DR_WIDTH-1:0]        status_meta;
	logic [DR_WIDTH-1:0]        status_sync;
	logic [1:0]                 sync_fill;
	logic                       upd_seen;

	assign user_sel = (ir == JTAP_IR_USER);

	// next state decode from tms
	always_comb
	begin
		next_state = JTAP_TLR;
		case (state)
			JTAP_TLR:  next_state = tms ? JTAP_TLR  : JTAP_RTI;
			JTAP_RTI:  next_state = tms ? JTAP_SDRS : JTAP_RTI;
			JTAP_SDRS: next_state = tms ? JTAP_SIRS : JTAP_CDR;
			JTAP_CDR:  next_state = tms ? JTAP_E1DR : JTAP_SDR;
			JTAP_SDR:  next_state = tms ? JTAP_E1DR : JTAP_SDR;
			JTAP_E1DR: next_state = tms ? JTAP_UDR  : JTAP_PDR;
			JTAP_PDR:  next_state = tms ? JTAP_E2DR : JTAP_PDR;
			JTAP_E2DR: next_state = tms ? JTAP_UDR  : JTAP_SDR;
			JTAP_UDR:  next_state = tms ? JTAP_SDRS : JTAP_RTI;
			JTAP_SIRS: next_state = tms ? JTAP_TLR  : JTAP_CIR;
			JTAP_CIR:  next_state = tms ? JTAP_E1IR : JTAP_SIR;
			JTAP_SIR:  next_state = tms ? JTAP_E1IR : JTAP_SIR;
			JTAP_E1IR: next_state = tms ? JTAP_UIR  : JTAP_PIR;
			JTAP_PIR:  next_state = tms ? JTAP_E2IR : JTAP_PIR;
			JTAP_E2IR: next_state = tms ? JTAP_UIR  : JTAP_SIR;
			JTAP_UIR:  next_state = tms ? JTAP_SDRS : JTAP_RTI;
			default:   next_state = JTAP_TLR;
		endcase
	end

	// tap state; only trst_n resets it, the system reset does not touch tck logic
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			state <= JTAP_TLR;
		else
			state <= next_state;
	end

	// instruction shift: capture pattern in capture-ir, lsb-first shift in shift-ir
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			ir_shift <= '0;
		else if (state == JTAP_CIR)
			ir_shift <= {{(IR_WIDTH-2){1'b0}}, JTAP_IR_CAPTURE};
		else if (state == JTAP_SIR)
			ir_shift <= {tdi, ir_shift[IR_WIDTH-1:1]};
	end

	// instruction takes ir_shift only in update-ir and reloads JTAP_IR_RESET in test-logic-reset, so an aborted scan keeps the old one
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			ir <= JTAP_IR_RESET[IR_WIDTH-1:0];
		else if (state == JTAP_TLR)
			ir <= JTAP_IR_RESET[IR_WIDTH-1:0];
		else if (state == JTAP_UIR)
			ir <= ir_shift;
	end

	// status word comes from the clk side: two tck stages before capture reads it;
	// the word must stand still for a few tck, there is no handshake back
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			status_meta <= '0;
		else
			status_meta <= user_status;
	end

	// second stage; only this one reads the first
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			status_sync <= '0;
		else
			status_sync <= status_meta;
	end

	// user data shift register
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			dr_shift <= '0;
		else if (state == JTAP_CDR)
			dr_shift <= status_sync;
		else if (state == JTAP_SDR)
			dr_shift <= {tdi, dr_shift[DR_WIDTH-1:1]};
	end

	// one-bit bypass stage, captures zero
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
			bypass_bit <= 1'b0;
		else if (state == JTAP_CDR)
			bypass_bit <= 1'b0;
		else if (state == JTAP_SDR)
			bypass_bit <= tdi;
	end

	// update-dr under any other instruction leaves the hold register alone;
	// the toggle carries the event so the clk side needs no pulse stretching
	always_ff @(posedge tck or negedge trst_n)
	begin
		if (!trst_n)
		begin
			dr_hold    <= JTAP_USER_RESET[DR_WIDTH-1:0];
			upd_toggle <= 1'b0;
		end
		else if (state == JTAP_UDR && user_sel)
		begin
			dr_hold    <= dr_shift;
			upd_toggle <= ~upd_toggle;
		end
	end

	// serial source: instruction path in shift-ir, else user word or bypass
	always_comb
	begin
		if (state == JTAP_SIR)
			serial_out = ir_shift[0];
		else if (user_sel)
			serial_out = dr_shift[0];
		else
			serial_out = bypass_bit;
	end

	// output retimed on falling edge so the host samples it on the next rising edge
	always_ff @(negedge tck or negedge trst_n)
	begin
		if (!trst_n)
			tdo <= 1'b0;
		else
			tdo <= serial_out;
	end

	// enable follows the state half a tck later, covering the whole shift window
	always_ff @(negedge tck or negedge trst_n)
	begin
		if (!trst_n)
			tdo_oe <= 1'b0;
		else
			tdo_oe <= (state == JTAP_SIR) || (state == JTAP_SDR);
	end

	// link side ends here; below runs on clk
	// update event crosses by toggle; dr_hold is stable for many clk cycles after it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			upd_sync <= 3'h0;
		else
			upd_sync <= {upd_sync[1:0], upd_toggle};
	end

	// after a system reset the chain refills from the standing toggle level;
	// updates wait until it is full so no stale word is replayed, at the cost of
	// losing an update that lands before the first clk edge after the reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sync_fill <= 2'h0;
		else if (sync_fill != JTAP_SYNC_FILL)
			sync_fill <= sync_fill + 2'h1;
	end

	assign upd_seen = (sync_fill == JTAP_SYNC_FILL) && (upd_sync[2] ^ upd_sync[1]);

	// one clk pulse per accepted update
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			user_update <= 1'b0;
		else
			user_update <= upd_seen;
	end

	// data stands until the next accepted update
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			user_data <= JTAP_USER_RESET[DR_WIDTH-1:0];
		else if (upd_seen)
			user_data <= dr_hold;
	end
endmodule

//--- jtap_props.sv
// assertions on the test port pins and the user_update and user_data outputs
`timescale 1ns/1ps
module jtap_props
(
	input wire logic        clk, rst, tck, tms, trst_n, tdo, tdo_oe, user_update,
	input wire logic [15:0] user_data
);
	a_tdo_hold:
	assert property (@(posedge clk) disable iff (!trst_n) tck && $past(tck) |-> $stable(tdo))
		else $error("tdo moved while tck high");
	a_tlr_quiet:
	assert property (@(posedge tck) disable iff (!trst_n) tms [*5] |=> !tdo_oe)
		else $error("tdo driven after five tms ones");
	a_dr_enter:
	assert property (@(posedge tck) disable iff (!trst_n)
		tms [*5] ##1 !tms ##1 tms ##1 !tms [*2] |=> tdo_oe) else $error("no drive in shift");
	a_exit_quiet:
	assert property (@(posedge tck) disable iff (!trst_n) tdo_oe && tms |=> !tdo_oe)
		else $error("tdo driven after shift");
	a_test_reset:
	assert property (@(posedge clk) !trst_n |-> !tdo_oe && !tdo) else $error("test reset ignored");
	a_update_pulse:
	assert property (@(posedge clk) disable iff (rst) user_update |=> !user_update)
		else $error("update longer than one cycle");
	a_data_cause:
	assert property (@(posedge clk) disable iff (rst) $changed(user_data) |-> user_update
		|| $past(user_update)) else $error("data changed without update");
	c_upd: cover property (@(posedge clk) user_update);
	c_shift: cover property (@(posedge tck) tdo_oe);
	c_sys: cover property (@(posedge clk) rst && trst_n);
endmodule

//--- jtap_host.sv
// behavioural jtag controller driving the test port
`timescale 1ns/1ps
module jtap_host
(
	output logic      tck, tms, tdi, trst_n,
	input  wire logic tdo, tdo_oe
);
	// tck rests low between frames, tms and tdi start at their pull-up level
	initial
	begin
		{tck, tms, tdi, trst_n} = 4'h7;
		#1 trst_n = 0;
	end
	task automatic step(input logic m, d, output logic q);
		{tms, tdi} = {m, d};
		#32 q = tdo_oe ? tdo : 1'bx;
		tck = 1;
		#32 tck = 0;
	endtask
	task automatic test_reset;
		logic q;
		trst_n = 0;
		#100 trst_n = 1;
		repeat (5) step(1, 1, q);
		step(0, 1, q);
	endtask
	task automatic scan(input logic ir, input logic [15:0] v, input int n, output logic [15:0] r);
		logic q;
		r = 0;
		step(1, 1, q);
		if (ir)
			step(1, 1, q);
		repeat (2) step(0, 1, q);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, v[i], q);
			r[i] = q;
		end
		step(1, 1, q);
		step(0, 1, q);
	endtask
endmodule

//--- tb.sv
// self-checking bench for the test access port
`timescale 1ns/1ps
module tb;
	import jtap_pkg::*;
	logic        clk = 0, rst = 1, tck, tms, tdi, trst_n, tdo, tdo_oe, user_update;
	logic [15:0] user_status = 16'h3C5A, user_data;
	int          n_fail = 0, checks_done = 0, cycles = 0;
	always #12.5 clk = ~clk;
	jtap_host host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe));
	jtap_top dut (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
		.tdo(tdo), .tdo_oe(tdo_oe), .user_status(user_status), .user_data(user_data),
		.user_update(user_update));
	task automatic check(input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_fail++;
			print_verdict();
		end
	end
	task automatic scan_dr(input logic [15:0] v);
		logic [15:0] r;
		int          i;
		host.scan(0, v, 16, r);
		check(r, user_status);
		for (i = 0; i < 20 && user_update !== 1'b1; i++) @(negedge clk);
		check(user_update, 1'b1);
		check(user_data, v);
		check(tdo_oe, 1'b0);
	endtask
	task automatic t_user;
		logic [15:0] r;
		host.scan(1, JTAP_IR_USER, 4, r);
		check(r, 16'h0001);
		scan_dr(16'hA5C3);
	endtask
	task automatic t_sysrst;
		@(posedge clk) rst <= 1;
		@(posedge clk) rst <= 0;
		check(user_data, 16'h0000);
		scan_dr(16'h1234);
	endtask
	task automatic t_bypass;
		logic [15:0] r;
		host.test_reset();
		host.scan(0, 16'h00B5, 8, r);
		check(r, 16'h006A);
		check(user_data, 16'h1234);
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 0;
		host.test_reset();
		t_user();
		t_sysrst();
		t_bypass();
		print_verdict();
	end
endmodule
bind jtap_top jtap_props props (.*);
